// File: aib_arbiter.sv
// Purpose: bid arbitration, threshold compare and winner capture for two channels
// Assumes: source events are one-cycle pulses synchronous to sys_clk_i
// Notes:   arbitration runs every second clock; register port is Avalon-MM
module aib_arbiter #(
    parameter int QUEUE_DEPTH = 256
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    input  wire logic [7:0]            avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic [31:0]                avs_readdata_o,
    output logic                       avs_waitrequest_o,
    input  wire aib_pkg::aib_chan_src_t src_a_i,
    input  wire aib_pkg::aib_chan_src_t src_b_i,
    input  wire logic                  interrupt_ack_low_i,
    output logic                       interrupt_request_low_o,
    output logic [3:0]                 winner_type_o,
    output logic                       winner_chan_o,
    output logic [7:0]                 winner_level_o
);

    localparam int CW = $clog2(QUEUE_DEPTH + 1);

    aib_pkg::aib_chan_src_t src [aib_pkg::NUM_CH];

    logic [31:0]                   mode_zero_r [aib_pkg::NUM_CH];
    logic [31:0]                   mode_one_r  [aib_pkg::NUM_CH];
    logic [31:0]                   mode_two_r  [aib_pkg::NUM_CH];
    logic [aib_pkg::STAT_W-1:0]    status_r    [aib_pkg::NUM_CH];
    logic [aib_pkg::STAT_W-1:0]    mask_r      [aib_pkg::NUM_CH];
    logic [aib_pkg::THR_W-1:0]     threshold_r;
    logic [31:0]                   fields0_r;
    logic [31:0]                   fields1_r;
    logic [aib_pkg::BID_W-1:0]     bid_lat_r   [aib_pkg::NUM_BIDS];
    logic [aib_pkg::BID_W-1:0]     bid_now     [aib_pkg::NUM_BIDS];
    logic [aib_pkg::BID_W-1:0]     cand_r;
    logic [aib_pkg::BID_W-1:0]     cand_nxt;
    logic [aib_pkg::BID_W-1:0]     winner_r;
    aib_pkg::aib_phase_t           phase_r;
    logic                          ack_prev_r;
    logic                          bus_ack_r;
    logic                          wr_go;
    logic                          update_cmd;
    logic                          ack_fall;
    logic                          cand_hits;
    logic [1:0]                    rx_level   [aib_pkg::NUM_CH];
    logic [1:0]                    tx_level   [aib_pkg::NUM_CH];
    logic                          rx_ready   [aib_pkg::NUM_CH];
    logic                          tx_ready   [aib_pkg::NUM_CH];
    logic [31:0]                   rd_word;

    assign src[0] = src_a_i;
    assign src[1] = src_b_i;

    // one wait cycle per access keeps the read mux off the request path
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~bus_ack_r;
    assign wr_go             = avs_write_i & bus_ack_r;
    assign update_cmd        = wr_go && (avs_address_i == aib_pkg::OFS_UPDATE);
    assign ack_fall          = ack_prev_r & ~interrupt_ack_low_i;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bus_ack_r <= 1'b0;
        end else begin
            bus_ack_r <= (avs_read_i | avs_write_i) & ~bus_ack_r;
        end
    end

    // clip a queue count to the 8-bit bid field, saturating at full scale
    function automatic logic [aib_pkg::LEVEL_W-1:0] to_level(input logic [CW-1:0] cnt);
        if (cnt > CW'(8'hff)) begin
            return 8'hff;
        end
        return cnt[aib_pkg::LEVEL_W-1:0];
    endfunction : to_level

    function automatic logic level_met(input logic [1:0] sel, input logic [CW-1:0] cnt);
        logic met;
        met = 1'b0;
        unique case (sel)
            aib_pkg::LVL_ANY:  met = (cnt != '0);
            aib_pkg::LVL_HALF: met = (cnt >= CW'(QUEUE_DEPTH / 2));
            aib_pkg::LVL_3Q:   met = (cnt >= CW'((QUEUE_DEPTH * 3) / 4));
            aib_pkg::LVL_ALL:  met = (cnt >= CW'(QUEUE_DEPTH));
        endcase
        return met;
    endfunction : level_met

    always_comb begin
        for (int c = 0; c < aib_pkg::NUM_CH; c++) begin
            rx_level[c] = mode_zero_r[c][aib_pkg::MODE_LEVEL_LSB +: 2];
            tx_level[c] = mode_two_r[c][aib_pkg::MODE_LEVEL_LSB +: 2];
            rx_ready[c] = level_met(rx_level[c], CW'(src[c].rx_filled));
            tx_ready[c] = level_met(tx_level[c], CW'(src[c].tx_empty));
        end
    end

    // register writes other than status
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            threshold_r <= aib_pkg::THR_RESET;
            fields0_r   <= aib_pkg::REG_RESET;
            fields1_r   <= aib_pkg::REG_RESET;
            for (int c = 0; c < aib_pkg::NUM_CH; c++) begin
                mode_zero_r[c] <= aib_pkg::REG_RESET;
                mode_one_r[c]  <= aib_pkg::REG_RESET;
                mode_two_r[c]  <= aib_pkg::REG_RESET;
                mask_r[c]      <= '0;
            end
        end else if (wr_go) begin
            for (int c = 0; c < aib_pkg::NUM_CH; c++) begin
                if (avs_address_i == aib_pkg::OFS_MODE_ZERO + 8'(c) * aib_pkg::CH_STRIDE) begin
                    mode_zero_r[c] <= avs_writedata_i;
                end
                if (avs_address_i == aib_pkg::OFS_MODE_ONE + 8'(c) * aib_pkg::CH_STRIDE) begin
                    mode_one_r[c] <= avs_writedata_i;
                end
                if (avs_address_i == aib_pkg::OFS_MODE_TWO + 8'(c) * aib_pkg::CH_STRIDE) begin
                    mode_two_r[c] <= avs_writedata_i;
                end
                if (avs_address_i == aib_pkg::OFS_MASK + 8'(c) * aib_pkg::CH_STRIDE) begin
                    mask_r[c] <= avs_writedata_i[aib_pkg::STAT_W-1:0];
                end
            end
            if (avs_address_i == aib_pkg::OFS_ARB_CTRL) begin
                threshold_r <= avs_writedata_i[aib_pkg::THR_W-1:0];
            end
            if (avs_address_i == aib_pkg::OFS_FIELDS0) begin
                fields0_r <= avs_writedata_i;
            end
            if (avs_address_i == aib_pkg::OFS_FIELDS1) begin
                fields1_r <= avs_writedata_i;
            end
        end
    end

    // event bits are sticky, write one clears, a new event wins over the clear;
    // rx and tx bits follow the live fill condition and ignore writes
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (int c = 0; c < aib_pkg::NUM_CH; c++) begin
                status_r[c] <= '0;
            end
        end else begin
            for (int c = 0; c < aib_pkg::NUM_CH; c++) begin
                logic [aib_pkg::STAT_W-1:0] clr;
                logic [aib_pkg::STAT_W-1:0] set;
                clr = '0;
                set = '0;
                if (wr_go && avs_address_i == aib_pkg::OFS_STATUS + 8'(c) * aib_pkg::CH_STRIDE) begin
                    clr = avs_writedata_i[aib_pkg::STAT_W-1:0];
                end
                set[aib_pkg::ST_WD]   = src[c].ev_watchdog;
                set[aib_pkg::ST_BRK]  = src[c].ev_break;
                set[aib_pkg::ST_LB]   = src[c].ev_loop;
                set[aib_pkg::ST_COS]  = src[c].ev_pin;
                set[aib_pkg::ST_XON]  = src[c].ev_xon;
                set[aib_pkg::ST_CT]   = src[c].ev_ct;
                set[aib_pkg::ST_ADDR] = src[c].ev_addr;
                status_r[c] <= (status_r[c] & ~clr) | set;
                status_r[c][aib_pkg::ST_RX] <= rx_ready[c];
                status_r[c][aib_pkg::ST_TX] <= tx_ready[c];
            end
        end
    end

    // bid assembly, one slot per source; disabled or idle sources bid zero
    always_comb begin
        for (int c = 0; c < aib_pkg::NUM_CH; c++) begin
            logic [aib_pkg::STAT_W-1:0]  en;
            logic [aib_pkg::LEVEL_W-1:0] rxl;
            logic [aib_pkg::LEVEL_W-1:0] txl;
            logic                        ch;
            int                          b;
            en  = status_r[c] & mask_r[c];
            rxl = to_level(CW'(src[c].rx_filled));
            txl = to_level(CW'(src[c].tx_empty));
            ch  = 1'(c);
            b   = c * aib_pkg::SRC_PER_CH;
            // receiver codes, break is not an error
            bid_now[b]     = en[aib_pkg::ST_RX] ? {rxl, src[c].rx_error ? aib_pkg::TY_RX_ERR
                                                  : aib_pkg::TY_RX_OK, ch} : aib_pkg::NO_BID;
            bid_now[b + 1] = en[aib_pkg::ST_WD] ? {rxl, aib_pkg::TY_RX_WD, ch} : aib_pkg::NO_BID;
            bid_now[b + 2] = en[aib_pkg::ST_TX] ? {txl, aib_pkg::TY_TX, ch} : aib_pkg::NO_BID;
            bid_now[b + 3] = en[aib_pkg::ST_BRK]  ? {fields0_r[6:0], aib_pkg::TY_BREAK, ch}
                                                  : aib_pkg::NO_BID;
            bid_now[b + 4] = en[aib_pkg::ST_LB]   ? {fields0_r[13:7], aib_pkg::TY_LOOP, ch}
                                                  : aib_pkg::NO_BID;
            bid_now[b + 5] = en[aib_pkg::ST_COS]  ? {fields0_r[20:14], aib_pkg::TY_PIN, ch}
                                                  : aib_pkg::NO_BID;
            bid_now[b + 6] = en[aib_pkg::ST_XON]  ? {fields1_r[6:0], aib_pkg::TY_XON, ch}
                                                  : aib_pkg::NO_BID;
            bid_now[b + 7] = en[aib_pkg::ST_CT]   ? {fields1_r[13:7], aib_pkg::TY_CT, ch}
                                                  : aib_pkg::NO_BID;
            bid_now[b + 8] = en[aib_pkg::ST_ADDR] ? {fields1_r[20:14], aib_pkg::TY_ADDR, ch}
                                                  : aib_pkg::NO_BID;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            phase_r <= aib_pkg::PH_SAMPLE;
        end else begin
            unique case (phase_r)
                aib_pkg::PH_SAMPLE: phase_r <= aib_pkg::PH_DECIDE;
                aib_pkg::PH_DECIDE: phase_r <= aib_pkg::PH_SAMPLE;
                default:            phase_r <= aib_pkg::PH_SAMPLE;
            endcase
        end
    end

    // bids frozen for the whole cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < aib_pkg::NUM_BIDS; i++) begin
                bid_lat_r[i] <= aib_pkg::NO_BID;
            end
        end else if (phase_r == aib_pkg::PH_SAMPLE) begin
            for (int i = 0; i < aib_pkg::NUM_BIDS; i++) begin
                bid_lat_r[i] <= bid_now[i];
            end
        end
    end

    // full-width compare lets channel b win ties
    always_comb begin
        cand_nxt = aib_pkg::NO_BID;
        for (int i = 0; i < aib_pkg::NUM_BIDS; i++) begin
            if (bid_lat_r[i] > cand_nxt) begin
                cand_nxt = bid_lat_r[i];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cand_r <= aib_pkg::NO_BID;
        end else if (phase_r == aib_pkg::PH_DECIDE) begin
            cand_r <= cand_nxt;
        end
    end

    // threshold against bid bits 11 to 1
    // zero threshold passes any nonzero bid
    assign cand_hits = cand_r[aib_pkg::BID_W-1:1] > threshold_r;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            interrupt_request_low_o <= 1'b1;
        end else begin
            interrupt_request_low_o <= ~cand_hits;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ack_prev_r <= 1'b1;
        end else begin
            ack_prev_r <= interrupt_ack_low_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            winner_r <= aib_pkg::NO_BID;
        end else if (ack_fall || update_cmd) begin
            winner_r <= cand_hits ? cand_r : aib_pkg::NO_BID;
        end
    end

    assign winner_level_o = winner_r[11:4];
    assign winner_type_o  = winner_r[4:1];
    assign winner_chan_o  = winner_r[0];

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_word = '0;
        for (int c = 0; c < aib_pkg::NUM_CH; c++) begin
            if (avs_address_i == aib_pkg::OFS_MODE_ZERO + 8'(c) * aib_pkg::CH_STRIDE) begin
                rd_word = mode_zero_r[c];
            end
            if (avs_address_i == aib_pkg::OFS_MODE_ONE + 8'(c) * aib_pkg::CH_STRIDE) begin
                rd_word = mode_one_r[c];
            end
            if (avs_address_i == aib_pkg::OFS_MODE_TWO + 8'(c) * aib_pkg::CH_STRIDE) begin
                rd_word = mode_two_r[c];
            end
            if (avs_address_i == aib_pkg::OFS_STATUS + 8'(c) * aib_pkg::CH_STRIDE) begin
                rd_word = 32'(mode_one_r[c][aib_pkg::MODE_ONE_MASKED_READ]
                              ? (status_r[c] & mask_r[c]) : status_r[c]);
            end
            if (avs_address_i == aib_pkg::OFS_MASK + 8'(c) * aib_pkg::CH_STRIDE) begin
                rd_word = 32'(mask_r[c]);
            end
        end
        if (avs_address_i == aib_pkg::OFS_ARB_CTRL) begin
            rd_word = 32'(threshold_r);
        end
        if (avs_address_i == aib_pkg::OFS_WINNER) begin
            rd_word = 32'(winner_r);
        end
        if (avs_address_i == aib_pkg::OFS_FIELDS0) begin
            rd_word = fields0_r;
        end
        if (avs_address_i == aib_pkg::OFS_FIELDS1) begin
            rd_word = fields1_r;
        end
        if (avs_address_i == aib_pkg::OFS_CANDIDATE) begin
            rd_word = 32'(cand_r);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && !bus_ack_r) begin
            avs_readdata_o <= rd_word;
        end
    end

endmodule : aib_arbiter

// File: aib_pkg.sv
// Purpose: shared constants and types for the arbitrating interrupt bid logic
// Assumes: 32-bit Avalon-MM register port, two serial channels
// Notes:   every register takes one aligned word; unused upper bits read zero
package aib_pkg;

    localparam int NUM_CH      = 2;
    localparam int BID_W       = 12;
    localparam int THR_W       = 11;
    localparam int FIELD_W     = 7;
    localparam int LEVEL_W     = 8;
    localparam int STAT_W      = 9;
    localparam int SRC_PER_CH  = 9;
    localparam int NUM_BIDS    = NUM_CH * SRC_PER_CH;

    // byte offsets, channel b sits one stride above channel a
    localparam logic [7:0] OFS_MODE_ZERO = 8'h00;
    localparam logic [7:0] OFS_MODE_ONE  = 8'h04;
    localparam logic [7:0] OFS_MODE_TWO  = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0c;
    localparam logic [7:0] OFS_MASK      = 8'h10;
    localparam logic [7:0] CH_STRIDE     = 8'h20;
    localparam logic [7:0] OFS_ARB_CTRL  = 8'h40;
    localparam logic [7:0] OFS_WINNER    = 8'h44;
    localparam logic [7:0] OFS_UPDATE    = 8'h48;
    localparam logic [7:0] OFS_FIELDS0   = 8'h4c;
    localparam logic [7:0] OFS_FIELDS1   = 8'h50;
    localparam logic [7:0] OFS_CANDIDATE = 8'h54;

    // status and mask bit positions
    localparam int ST_TX   = 0;
    localparam int ST_RX   = 1;
    localparam int ST_BRK  = 2;
    localparam int ST_CT   = 3;
    localparam int ST_XON  = 4;
    localparam int ST_ADDR = 5;
    localparam int ST_WD   = 6;
    localparam int ST_COS  = 7;
    localparam int ST_LB   = 8;

    // field positions inside the mode registers
    localparam int MODE_ONE_MASKED_READ = 6;
    localparam int MODE_LEVEL_LSB       = 4;

    // source type codes, fifo sources use only the low three bits
    localparam logic [2:0] TY_RX_OK   = 3'h1;
    localparam logic [2:0] TY_RX_ERR  = 3'h5;
    localparam logic [2:0] TY_RX_WD   = 3'h4;
    localparam logic [2:0] TY_TX      = 3'h2;
    localparam logic [3:0] TY_BREAK   = 4'he;
    localparam logic [3:0] TY_LOOP    = 4'hf;
    localparam logic [3:0] TY_PIN     = 4'h6;
    localparam logic [3:0] TY_XON     = 4'h7;
    localparam logic [3:0] TY_CT      = 4'h8;
    localparam logic [3:0] TY_ADDR    = 4'hb;
    localparam logic [3:0] TY_NONE    = 4'h0;

    localparam logic [BID_W-1:0]  NO_BID       = 12'h000;
    localparam logic [THR_W-1:0]  THR_RESET    = 11'h000;
    localparam logic [31:0]       REG_RESET    = 32'h0000_0000;
    localparam logic [1:0]        LVL_ANY      = 2'h0;
    localparam logic [1:0]        LVL_HALF     = 2'h1;
    localparam logic [1:0]        LVL_3Q       = 2'h2;
    localparam logic [1:0]        LVL_ALL      = 2'h3;

    // one channel's live source signals; counts are 9 bits for a 256 deep queue
    typedef struct packed {
        logic [8:0] rx_filled;
        logic [8:0] tx_empty;
        logic       rx_error;
        logic       ev_watchdog;
        logic       ev_break;
        logic       ev_loop;
        logic       ev_pin;
        logic       ev_xon;
        logic       ev_ct;
        logic       ev_addr;
    } aib_chan_src_t;

    typedef struct packed {
        logic [LEVEL_W-1:0] level;
        logic [3:0]         kind;
        logic               chan;
    } aib_bid_t;

    typedef enum logic [1:0] {
        PH_SAMPLE = 2'b01,
        PH_DECIDE = 2'b10
    } aib_phase_t;

endpackage : aib_pkg

// File: aib_arbiter_properties.sv
// Purpose: port-level checks of the arbitrating interrupt bid logic
// Assumes: master holds each request until waitrequest is low
// Notes:   capture checks want a steady request first
module aib_arbiter_properties #(
    parameter int QUEUE_DEPTH = 256
) (
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic       avs_read_i,
    input wire logic       avs_write_i,
    input wire logic       avs_waitrequest_o,
    input wire logic       interrupt_ack_low_i,
    input wire logic       interrupt_request_low_o,
    input wire logic [3:0] winner_type_o,
    input wire logic       winner_chan_o,
    input wire logic [7:0] winner_level_o
);
    default clocking cb_main @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    logic        wrote_r;
    logic        ack_prev_r;
    logic        ack_fall;
    logic        upd;
    logic [11:0] captured_winner_reg;
    assign captured_winner_reg      = {winner_level_o, winner_type_o[2:0], winner_chan_o};
    assign ack_fall = ack_prev_r & ~interrupt_ack_low_i;
    assign upd      = avs_write_i & ~avs_waitrequest_o & (avs_address_i == aib_pkg::OFS_UPDATE);
    always_ff @(posedge sys_clk_i) begin
        ack_prev_r <= rst_i | interrupt_ack_low_i;
    end
    // no write yet means every mask is still clear
    always_ff @(posedge sys_clk_i) begin
        wrote_r <= ~rst_i & (wrote_r | avs_write_i);
    end
    property p_wait_one;
        (avs_read_i | avs_write_i) & avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("more than one wait state");
    property p_idle;
        !(avs_read_i | avs_write_i) |-> !avs_waitrequest_o;
    endproperty
    a_idle: assert property (p_idle)
        else $error("waitrequest high while idle");
    property p_quiet;
        !wrote_r |-> interrupt_request_low_o;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("request with every source masked");
    property p_pace;
        $changed(interrupt_request_low_o) |=> $stable(interrupt_request_low_o);
    endproperty
    a_pace: assert property (p_pace)
        else $error("request changed faster than arbitration");
    property p_hold;
        $changed(captured_winner_reg) |-> $past(ack_fall) || $past(ack_fall, 2) || $past(upd);
    endproperty
    a_hold: assert property (p_hold)
        else $error("captured winner changed without trigger");
    property p_none_zero;
        winner_type_o == aib_pkg::TY_NONE |-> captured_winner_reg == aib_pkg::NO_BID;
    endproperty
    a_none_zero: assert property (p_none_zero)
        else $error("no-source type with nonzero fields");
    property p_cap_empty;
        interrupt_request_low_o [*6] ##1 upd |=> captured_winner_reg == aib_pkg::NO_BID;
    endproperty
    a_cap_empty: assert property (p_cap_empty)
        else $error("capture without request not zero");
    property p_cap_win;
        !interrupt_request_low_o [*6] ##1 ack_fall |-> ##[1:2] winner_type_o != aib_pkg::TY_NONE;
    endproperty
    a_cap_win: assert property (p_cap_win)
        else $error("acknowledge during request captured nothing");
endmodule : aib_arbiter_properties
bind aib_arbiter aib_arbiter_properties #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_aib_arbiter_properties (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .interrupt_ack_low_i(interrupt_ack_low_i), .interrupt_request_low_o(interrupt_request_low_o),
    .winner_type_o(winner_type_o), .winner_chan_o(winner_chan_o),
    .winner_level_o(winner_level_o));

// File: aib_host_model.sv
// Purpose: host side that acknowledges a pending interrupt request
// Assumes: serve_i is a one-cycle go from the bench
// Notes:   acknowledge held low for two cycles
module aib_host_model (
    input  wire logic sys_clk_i,
    input  wire logic serve_i,
    input  wire logic interrupt_request_low_i,
    output logic      interrupt_ack_low_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial interrupt_ack_low_o = 1'b1;
    always @(posedge sys_clk_i) begin
        if (serve_i && !interrupt_request_low_i) begin
            interrupt_ack_low_o <= 1'b0;
            repeat (2) @(posedge sys_clk_i);
            interrupt_ack_low_o <= 1'b1;
        end
    end
endmodule : aib_host_model

// File: tb_top.sv
// Purpose: self-checking bench for the arbitrating interrupt bid logic
// Assumes: 20 MHz clock, registers reached over Avalon-MM
// Notes:   one table row per bid case, awkward cases after
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [3:0]  rxa;
        logic [3:0]  rxb;
        logic [3:0]  txb;
        logic        erra;
        logic [6:0]  eva;
        logic [6:0]  evb;
        logic [8:0]  mska;
        logic [8:0]  mskb;
        logic [10:0] thr;
        logic [11:0] captured_winner_reg;
    } aib_row_t;
    localparam aib_row_t ROWS [0:15] = '{
        '{4'h5, 4'h0, 4'h0, 1'h0, 7'h00, 7'h00, 9'h002, 9'h000, 11'h000, 12'h052},
        '{4'h5, 4'h0, 4'h0, 1'h1, 7'h00, 7'h00, 9'h002, 9'h000, 11'h000, 12'h05a},
        '{4'h5, 4'h5, 4'h0, 1'h0, 7'h00, 7'h00, 9'h002, 9'h002, 11'h000, 12'h053},
        '{4'h0, 4'h0, 4'h3, 1'h0, 7'h00, 7'h00, 9'h000, 9'h001, 11'h000, 12'h035},
        '{4'h5, 4'h0, 4'h0, 1'h0, 7'h00, 7'h00, 9'h001, 9'h000, 11'h000, 12'h000},
        '{4'h5, 4'h0, 4'h0, 1'h0, 7'h00, 7'h00, 9'h002, 9'h000, 11'h029, 12'h000},
        '{4'h5, 4'h0, 4'h0, 1'h0, 7'h00, 7'h00, 9'h002, 9'h000, 11'h028, 12'h052},
        '{4'h0, 4'h5, 4'h0, 1'h0, 7'h00, 7'h00, 9'h000, 9'h002, 11'h029, 12'h000},
        '{4'h0, 4'h0, 4'h0, 1'h0, 7'h20, 7'h00, 9'h004, 9'h000, 11'h000, 12'h01c},
        '{4'h0, 4'h0, 4'h0, 1'h0, 7'h10, 7'h00, 9'h100, 9'h000, 11'h000, 12'h01e},
        '{4'h0, 4'h0, 4'h0, 1'h0, 7'h00, 7'h08, 9'h000, 9'h080, 11'h000, 12'h00d},
        '{4'h0, 4'h0, 4'h0, 1'h0, 7'h04, 7'h00, 9'h010, 9'h000, 11'h000, 12'h00e},
        '{4'h0, 4'h0, 4'h0, 1'h0, 7'h00, 7'h02, 9'h000, 9'h008, 11'h000, 12'h011},
        '{4'h0, 4'h0, 4'h0, 1'h0, 7'h00, 7'h01, 9'h000, 9'h020, 11'h000, 12'h017},
        '{4'h2, 4'h0, 4'h0, 1'h0, 7'h40, 7'h00, 9'h040, 9'h000, 11'h000, 12'h028},
        '{4'h3, 4'h0, 4'h0, 1'h0, 7'h00, 7'h20, 9'h002, 9'h004, 11'h000, 12'h032}};
    logic                   clk;
    logic                   rst;
    logic [7:0]             addr;
    logic                   rd_en;
    logic                   wr_en;
    logic [31:0]            wdata;
    logic [31:0]            rdata;
    logic                   wait_req;
    aib_pkg::aib_chan_src_t src_a;
    aib_pkg::aib_chan_src_t src_b;
    logic                   ack_low;
    logic                   irq_low;
    logic                   serve;
    logic [3:0]             win_type;
    logic                   win_chan;
    logic [7:0]             win_level;
    logic [31:0]            d;
    int                     failures;
    int                     num_checks;
    aib_arbiter u_aib_arbiter (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
        .src_a_i(src_a), .src_b_i(src_b), .interrupt_ack_low_i(ack_low),
        .interrupt_request_low_o(irq_low), .winner_type_o(win_type),
        .winner_chan_o(win_chan), .winner_level_o(win_level));
    aib_host_model u_aib_host_model (.sys_clk_i(clk), .serve_i(serve),
        .interrupt_request_low_i(irq_low), .interrupt_ack_low_o(ack_low));
    always #25 clk = ~clk;
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (!ok) begin
            failures++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        addr <= a;
        wr_en <= wr;
        rd_en <= !wr;
        wdata <= wd;
        @(posedge clk iff !wait_req);
        d = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask : bus
    task automatic run_row(input aib_row_t r);
        bus(1'b1, aib_pkg::OFS_ARB_CTRL, {21'h000000, r.thr});
        bus(1'b1, aib_pkg::OFS_MASK, {23'h000000, r.mska});
        bus(1'b1, aib_pkg::OFS_MASK + aib_pkg::CH_STRIDE, {23'h000000, r.mskb});
        src_a <= {5'h00, r.rxa, 9'h000, r.erra, r.eva};
        src_b <= {5'h00, r.rxb, 5'h00, r.txb, 1'b0, r.evb};
        @(posedge clk);
        src_a <= {5'h00, r.rxa, 9'h000, r.erra, 7'h00};
        src_b <= {5'h00, r.rxb, 5'h00, r.txb, 8'h00};
        repeat (8) @(posedge clk);
        chk(irq_low === (r.captured_winner_reg == 12'h000), "request level");
        bus(1'b1, aib_pkg::OFS_UPDATE, 32'h0000_0000);
        bus(1'b0, aib_pkg::OFS_WINNER, 32'h0000_0000);
        chk(d[11:0] === r.captured_winner_reg, "captured winner");
        chk({win_level, win_type[2:0], win_chan} === r.captured_winner_reg, "winner ports");
        src_a <= '0;
        src_b <= '0;
        bus(1'b1, aib_pkg::OFS_STATUS, 32'h0000_01ff);
        bus(1'b1, aib_pkg::OFS_STATUS + aib_pkg::CH_STRIDE, 32'h0000_01ff);
    endtask : run_row
    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    initial begin
        #250000;
        failures++;
        end_sim();
    end
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        addr = 8'h00;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdata = 32'h0000_0000;
        src_a = '0;
        src_b = '0;
        serve = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            run_row(ROWS[i]);
            $display("row %0d done", i);
        end
        bus(1'b1, aib_pkg::OFS_MASK, 32'h0000_0000);
        src_a <= 26'h0000020;
        @(posedge clk);
        src_a <= '0;
        bus(1'b0, aib_pkg::OFS_STATUS, 32'h0000_0000);
        chk(d === 32'h0000_0004, "raw status");
        bus(1'b1, aib_pkg::OFS_MODE_ONE, 32'h0000_0040);
        bus(1'b0, aib_pkg::OFS_STATUS, 32'h0000_0000);
        chk(d === 32'h0000_0000, "masked status");
        bus(1'b0, 8'hfc, 32'h0000_0000);
        chk(d === 32'h0000_0000, "unmapped read");
        $display("status test done");
        bus(1'b1, aib_pkg::OFS_STATUS, 32'h0000_01ff);
        bus(1'b1, aib_pkg::OFS_MASK, 32'h0000_0002);
        src_a <= 26'h00a0000;
        repeat (8) @(posedge clk);
        serve <= 1'b1;
        @(posedge clk);
        serve <= 1'b0;
        repeat (6) @(posedge clk);
        chk(win_level === 8'h05 && win_type === 4'h9, "acknowledged winner");
        src_a <= 26'h00e0000;
        repeat (8) @(posedge clk);
        chk(win_level === 8'h05, "winner held");
        bus(1'b1, aib_pkg::OFS_UPDATE, 32'h0000_0000);
        bus(1'b0, aib_pkg::OFS_WINNER, 32'h0000_0000);
        chk(d[11:4] === 8'h07, "updated winner");
        bus(1'b1, aib_pkg::OFS_MODE_ZERO, 32'h0000_0010);
        repeat (8) @(posedge clk);
        chk(irq_low === 1'b1, "start level");
        $display("acknowledge test done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(irq_low === 1'b1 && {win_level, win_type, win_chan} === 13'h0000, "reset outputs");
        bus(1'b0, aib_pkg::OFS_MASK, 32'h0000_0000);
        chk(d === 32'h0000_0000, "mask after reset");
        $display("reset test done");
        end_sim();
    end
endmodule : tb_top
